// ### common/line_ctrl_pkg.sv
// Package with register map, field layout, timing counts and state types of the I/O line block.
package line_ctrl_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] LINE_CFG_ADDR    = 8'h00;
  localparam logic [7:0] PULSE_DELAY_ADDR = 8'h04;
  localparam logic [7:0] LINE_STAT_ADDR   = 8'h08;

  // Field positions inside the line configuration register.
  localparam int CFG_PIN_CHOICE_BIT = 0;
  localparam int CFG_FLIP_BIT       = 1;
  localparam int CFG_SOURCE_LSB     = 2;
  localparam int CFG_LEVEL_BIT      = 4;

  // Field positions inside the line status register.
  localparam int STAT_TRIG_BIT  = 0;
  localparam int STAT_PIN_BIT   = 1;
  localparam int STAT_PULSE_BIT = 2;
  localparam int STAT_OE_N_BIT  = 3;

  // Reset values.
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Timing: clock rate, microsecond tick and the exposure pulse start latency bound.
  localparam int CLOCK_MHZ          = 250;
  localparam int TICK_US            = 1;
  localparam int TICK_CYCLES        = TICK_US * CLOCK_MHZ;
  localparam int START_LATENCY_NS   = 800;
  localparam int START_LATENCY_CYC  = (START_LATENCY_NS * CLOCK_MHZ) / 1000;
  localparam int DELAY_WIDTH        = 16;

  // Output line source choice.
  typedef enum logic [1:0] {
    SRC_OFF      = 2'b00,
    SRC_FRAME    = 2'b01,
    SRC_EXPOSURE = 2'b10,
    SRC_SOFTWARE = 2'b11
  } line_source_type;

  // Whole state of the line block.
  typedef struct packed {
    logic                   io_pin_choice;
    logic                   flip_in;
    logic                   output_polarity_flip;
    line_source_type        source;
    logic                   software_level_setting;
    logic [DELAY_WIDTH-1:0] exposure_pulse_delay_us;
    logic [2:0]             trig_sync;
    logic                   trig_level;
    logic                   exposure_d;
    logic [7:0]             tick_cnt;
    logic                   tick;
    logic                   rise_pend;
    logic [DELAY_WIDTH-1:0] rise_cnt;
    logic                   fall_pend;
    logic [DELAY_WIDTH-1:0] fall_cnt;
    logic                   pulse;
    logic                   pin;
    logic                   pin_oe_n;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } line_state_type;

endpackage

// ### src/camera_output_line_control.sv
// Control I/O line logic: APB registers, input line sampling and output line source selection.
//
// Contract
// R1: A selector chooses whether line settings apply to the input or the output line.
// R2: Polarity flip on inverts the output line; off drives it unchanged.
// R3: Output source off leaves the output line undriven.
// R4: Readout-window source drives the line high throughout each frame readout.
// R5: Exposure source drives a pulse marking exposure, shifted by the programmed delay.
// R6: Software source drives the line to the software level setting.
// R7: Exposure pulse delay is 0 to 65535 whole microseconds, used only for exposure source.
// R8: Exposure pulse rises at exposure start and falls at exposure end.
// R9: Exposure pulse rise lags real exposure start by at most 0.8 us.
// R10: A one-microsecond tick from the system clock times the exposure pulse delay.
// R11: After reset the source is off, inversion off and software level low.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module camera_output_line_control
  import line_ctrl_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  input  wire logic        trigger_input_pin_i,
  input  wire logic        frame_readout_i,
  input  wire logic        exposure_active_i,
  output logic             trigger_level_o,
  output logic             signal_output_pin_o,
  output logic             signal_output_pin_oe_n_o
);

  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  localparam int LAT_MAX = START_LATENCY_CYC;

  line_state_type state_r;
  line_state_type state_nxt;

  // True for a byte address that maps onto one of the three registers.
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == LINE_CFG_ADDR) || (addr == PULSE_DELAY_ADDR) ||
                  (addr == LINE_STAT_ADDR);
  endfunction

  logic apb_setup;
  logic apb_write;
  logic exp_rise;
  logic exp_fall;
  logic delayed;
  logic rise_due;

  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && state_r.pready && pwrite_i;
  assign exp_rise  = exposure_active_i && !state_r.exposure_d;
  assign exp_fall  = !exposure_active_i && state_r.exposure_d;
  assign delayed   = (state_r.exposure_pulse_delay_us != DELAY_RESET);
  assign rise_due  = state_r.rise_pend && state_r.tick && (state_r.rise_cnt == 16'h0001);

  // Next state of the whole block. Reads are decoded in the setup cycle so that read data
  // and pready come straight from flip-flops in the access cycle, at zero wait states.
  always_comb
  begin
    state_nxt = state_r;

    // APB answer: ready for one cycle after each setup cycle.
    state_nxt.pready  = apb_setup;
    state_nxt.pslverr = apb_setup && !addr_mapped(paddr_i);
    state_nxt.prdata  = RDATA_RESET;
    if (apb_setup && !pwrite_i)
    begin
      case (paddr_i)
        LINE_CFG_ADDR:
        begin
          state_nxt.prdata[CFG_PIN_CHOICE_BIT] = state_r.io_pin_choice;
          // The flip bit read back belongs to the line that the selector points at.
          state_nxt.prdata[CFG_FLIP_BIT] = state_r.io_pin_choice ?
            state_r.output_polarity_flip : state_r.flip_in; // R1
          state_nxt.prdata[CFG_SOURCE_LSB +: 2] = state_r.source;
          state_nxt.prdata[CFG_LEVEL_BIT]       = state_r.software_level_setting;
        end
        PULSE_DELAY_ADDR: state_nxt.prdata[DELAY_WIDTH-1:0] = state_r.exposure_pulse_delay_us;
        LINE_STAT_ADDR:
        begin
          state_nxt.prdata[STAT_TRIG_BIT]  = state_r.trig_level;
          state_nxt.prdata[STAT_PIN_BIT]   = state_r.pin;
          state_nxt.prdata[STAT_PULSE_BIT] = state_r.pulse;
          state_nxt.prdata[STAT_OE_N_BIT]  = state_r.pin_oe_n;
        end
        default: state_nxt.prdata = RDATA_RESET;
      endcase
    end

    // Register writes take effect at the access edge with pready high.
    if (apb_write && (paddr_i == LINE_CFG_ADDR))
    begin
      state_nxt.io_pin_choice = pwdata_i[CFG_PIN_CHOICE_BIT];
      // Only the line named by the newly written selector takes the flip bit.
      if (pwdata_i[CFG_PIN_CHOICE_BIT])
        state_nxt.output_polarity_flip = pwdata_i[CFG_FLIP_BIT]; // R1
      else
        state_nxt.flip_in = pwdata_i[CFG_FLIP_BIT]; // R1
      state_nxt.source = line_source_type'(pwdata_i[CFG_SOURCE_LSB +: 2]);
      state_nxt.software_level_setting = pwdata_i[CFG_LEVEL_BIT];
    end
    if (apb_write && (paddr_i == PULSE_DELAY_ADDR))
      state_nxt.exposure_pulse_delay_us = pwdata_i[DELAY_WIDTH-1:0]; // R7

    // Trigger pin: three flops, a change counts once the last two agree.
    state_nxt.trig_sync = {state_r.trig_sync[1:0], trigger_input_pin_i};
    if (state_r.trig_sync[2] == state_r.trig_sync[1])
      state_nxt.trig_level = state_r.trig_sync[2] ^ state_r.flip_in;

    // Free-running microsecond tick; one-cycle enable pulse.
    state_nxt.tick = (state_r.tick_cnt == TICK_LAST); // R10
    state_nxt.tick_cnt = state_nxt.tick ? 8'h00 : state_r.tick_cnt + 8'h01; // R10

    // Exposure pulse with optional delay. Rise and fall each keep one pending edge, so an
    // exposure shorter than the delay still gives one pulse; a third edge arriving while
    // both are pending overwrites the older one, a limitation of this two-timer scheme.
    state_nxt.exposure_d = exposure_active_i;
    if (!delayed)
    begin
      state_nxt.pulse     = exposure_active_i; // R8
      state_nxt.rise_pend = 1'b0;
      state_nxt.fall_pend = 1'b0;
    end
    else
    begin
      if (state_r.rise_pend && state_r.tick)
      begin
        if (state_r.rise_cnt == 16'h0001)
        begin
          state_nxt.rise_pend = 1'b0;
          state_nxt.pulse     = 1'b1; // R5
        end
        state_nxt.rise_cnt = state_r.rise_cnt - 16'h0001; // R10
      end
      // A fall due in the same tick as its rise waits one tick more. Otherwise a short
      // exposure between two ticks would vanish, because both edges share one tick.
      if (state_r.fall_pend && state_r.tick && !(rise_due && (state_r.fall_cnt == 16'h0001)))
      begin
        if (state_r.fall_cnt == 16'h0001)
        begin
          state_nxt.fall_pend = 1'b0;
          state_nxt.pulse     = 1'b0; // R5
        end
        state_nxt.fall_cnt = state_r.fall_cnt - 16'h0001; // R10
      end
      // A fresh edge restarts its timer; it wins over an expiry in the same cycle.
      if (exp_rise)
      begin
        state_nxt.rise_pend = 1'b1; // R5
        state_nxt.rise_cnt  = state_r.exposure_pulse_delay_us;
      end
      if (exp_fall)
      begin
        state_nxt.fall_pend = 1'b1; // R5
        state_nxt.fall_cnt  = state_r.exposure_pulse_delay_us;
      end
    end

    // Output line source selection, then polarity flip.
    state_nxt.pin_oe_n = 1'b0;
    case (state_r.source)
      SRC_OFF:
      begin
        state_nxt.pin      = 1'b0;
        state_nxt.pin_oe_n = 1'b1; // R3
      end
      SRC_FRAME:    state_nxt.pin = frame_readout_i ^ state_r.output_polarity_flip; // R4 R2
      // Undelayed, the raw level is used so the rise lags exposure start by only one cycle.
      SRC_EXPOSURE: state_nxt.pin = (delayed ? state_r.pulse : exposure_active_i) ^
                                    state_r.output_polarity_flip; // R5 R9 R2
      SRC_SOFTWARE: state_nxt.pin = state_r.software_level_setting ^
                                    state_r.output_polarity_flip; // R6 R2
      default:
      begin
        state_nxt.pin      = 1'b0;
        state_nxt.pin_oe_n = 1'b1;
      end
    endcase
  end

  // State register with synchronous reset to the quiet defaults.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state_r <= '0;
      state_r.source   <= SRC_OFF; // R11
      state_r.pin_oe_n <= 1'b1;    // R11
      state_r.exposure_pulse_delay_us <= DELAY_RESET;
      state_r.prdata   <= RDATA_RESET;
    end
    else
      state_r <= state_nxt;
  end

  // Every output comes straight from a state flip-flop.
  assign pready_o                 = state_r.pready;
  assign pslverr_o                = state_r.pslverr;
  assign prdata_o                 = state_r.prdata;
  assign trigger_level_o          = state_r.trig_level;
  assign signal_output_pin_o      = state_r.pin;
  assign signal_output_pin_oe_n_o = state_r.pin_oe_n;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  chk_reset_quiet_defaults: assert property ( // R11
    $rose(resetn_i) |-> signal_output_pin_oe_n_o && (state_r.source == SRC_OFF) &&
                        !state_r.output_polarity_flip && !state_r.software_level_setting)
    else $error("Line settings not at defaults after reset.");

  chk_off_released: assert property ( // R3
    (state_r.source == SRC_OFF) |=> signal_output_pin_oe_n_o)
    else $error("Output line driven while source is off.");

  chk_software_level_flip: assert property ( // R6
    (state_r.source == SRC_SOFTWARE) |=>
      !signal_output_pin_oe_n_o &&
      (signal_output_pin_o == ($past(state_r.software_level_setting) ^
                               $past(state_r.output_polarity_flip))))
    else $error("Software level not driven with the selected polarity.");

  chk_frame_follow: assert property ( // R4
    (state_r.source == SRC_FRAME) && !state_r.output_polarity_flip && frame_readout_i
      |=> signal_output_pin_o)
    else $error("Readout window not shown on the output line.");

  chk_frame_inverted: assert property ( // R2
    (state_r.source == SRC_FRAME) && state_r.output_polarity_flip && frame_readout_i
      |=> !signal_output_pin_o)
    else $error("Inverted output not low during readout.");

  chk_start_latency: assert property ( // R9
    $rose(exposure_active_i) && !delayed && (state_r.source == SRC_EXPOSURE) &&
      !state_r.output_polarity_flip ##1 exposure_active_i[*2]
      |-> ##[0:LAT_MAX] signal_output_pin_o)
    else $error("Exposure pulse rise later than the start latency.");

  chk_delay_holds_off: assert property ( // R5
    $rose(exposure_active_i) && (state_r.exposure_pulse_delay_us == 16'h0002) && !state_r.pulse
      && !state_r.fall_pend |=> !state_r.pulse [*8])
    else $error("Delayed exposure pulse rose too early.");

  chk_tick_spacing: assert property ( // R10
    state_r.tick |=> !state_r.tick [*8])
    else $error("Microsecond tick repeats too soon.");

  chk_input_flip_kept: assert property ( // R1
    apb_write && (paddr_i == LINE_CFG_ADDR) && !pwdata_i[CFG_PIN_CHOICE_BIT]
      |=> $stable(state_r.output_polarity_flip))
    else $error("Input-line write altered the output flip setting.");

  chk_apb_ready: assert property (
    apb_setup |=> pready_o ##1 !pready_o)
    else $error("APB ready not a single cycle after setup.");

  chk_short_pulse_kept: assert property ( // R5
    state_r.tick && state_r.rise_pend && state_r.fall_pend && (state_r.rise_cnt == 16'h0001)
      && delayed |=> state_r.pulse)
    else $error("Short delayed exposure lost its pulse.");

endmodule

`default_nettype wire

// ### bench/line_equipment_model.sv
// Flash equipment on the output line: pulled-down wire level and a count of flashes.
`timescale 1ns/1ps
`default_nettype none
module line_equipment_model (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       pin_i,
  input  wire logic       oe_n_i,
  output logic            line_o,
  output logic [7:0]      flashes_o
);
  logic seen_r;
  // The wire has a pull-down, so a released line reads low and never keeps the last level.
  assign line_o = oe_n_i ? 1'b0 : pin_i;
  // A flash fires on every rising edge of the wire; the count shows pulses that were merged.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      seen_r    <= 1'b0;
      flashes_o <= 8'h00;
    end
    else
    begin
      seen_r <= line_o;
      if (line_o && !seen_r)
        flashes_o <= flashes_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_camera_output_line_control.sv
// Self-checking bench of the control I/O line block with an APB master and flash model.
`timescale 1ns/1ps
`default_nettype none
module tb_camera_output_line_control;
  import line_ctrl_pkg::*;
  logic        clock_i, resetn_i, psel, penable, pwrite, trig_pin, frame, expo;
  logic        pready, pslverr, trig_lvl, pin, oe_n, line, er;
  logic [7:0]  paddr, flashes, fl0;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches = 0;
  int          checks_done = 0;
  int          n;
  // Each row: line config [8:4], readout [3], exposure [2], wire level [1], enable low [0].
  logic [8:0]  rows [11] = '{9'h011, 9'h05a, 9'h050, 9'h078, 9'h072, 9'h096, 9'h090,
                             9'h1d2, 9'h0d0, 9'h1f0, 9'h03d};

  camera_output_line_control dut (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .trigger_input_pin_i(trig_pin),
    .frame_readout_i(frame), .exposure_active_i(expo), .trigger_level_o(trig_lvl),
    .signal_output_pin_o(pin), .signal_output_pin_oe_n_o(oe_n));
  line_equipment_model partner (.clock_i(clock_i), .resetn_i(resetn_i), .pin_i(pin),
    .oe_n_i(oe_n), .line_o(line), .flashes_o(flashes));

  // A 4 ns clock.
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so that a following call never drives psel twice in one step.
    @(posedge clock_i);
    if (k >= 16)
    begin
      mismatches++;
      end_of_test();
    end
  endtask

  // Waits for the wire to reach a level, counting edges in n; a stuck wire ends the run.
  task automatic wait_line(input logic lvl);
    n = 0;
    while (line !== lvl && n < 1000)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 1000)
    begin
      mismatches++;
      end_of_test();
    end
  endtask

  // Cuts a hung run short.
  initial
  begin
    repeat (100000) @(posedge clock_i);
    mismatches++;
    end_of_test();
  end

  // Main sequence: reset values, table of sources, then the timed and awkward cases.
  initial
  begin
    resetn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trig_pin = 1'b0;
    frame = 1'b0;
    expo = 1'b0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    chk({31'h0, oe_n}, 32'h1);
    apb(1'b0, LINE_CFG_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, PULSE_DELAY_ADDR, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, LINE_CFG_ADDR, {27'h0, rows[i][8:4]});
      frame <= rows[i][3];
      expo  <= rows[i][2];
      repeat (3) @(posedge clock_i);
      chk({30'h0, line, oe_n}, {30'h0, rows[i][1:0]});
    end
    // Undelayed exposure pulse: both edges follow the exposure within the start bound.
    apb(1'b1, LINE_CFG_ADDR, 32'h9);
    expo <= 1'b0;
    repeat (4) @(posedge clock_i);
    expo <= 1'b1;
    wait_line(1'b1);
    chk({31'h0, n <= START_LATENCY_CYC}, 32'h1);
    expo <= 1'b0;
    wait_line(1'b0);
    chk({31'h0, n <= START_LATENCY_CYC}, 32'h1);
    // The flip bit follows the selector: input line first, then the output line.
    apb(1'b1, LINE_CFG_ADDR, 32'h2);
    repeat (6) @(posedge clock_i);
    chk({31'h0, trig_lvl}, 32'h1);
    apb(1'b0, LINE_CFG_ADDR, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, LINE_CFG_ADDR, 32'h1d);
    repeat (6) @(posedge clock_i);
    apb(1'b0, LINE_STAT_ADDR, 32'h0);
    chk(rd, 32'h3);
    // Delay of 2 us with an exposure shorter than the delay still gives one late pulse.
    apb(1'b1, PULSE_DELAY_ADDR, 32'h2);
    apb(1'b1, LINE_CFG_ADDR, 32'h9);
    wait_line(1'b0);
    fl0 = flashes;
    expo <= 1'b1;
    repeat (20) @(posedge clock_i);
    expo <= 1'b0;
    wait_line(1'b1);
    chk({31'h0, (n + 20 >= TICK_CYCLES) && (n + 20 <= 2 * TICK_CYCLES + 3)}, 32'h1);
    wait_line(1'b0);
    repeat (4) @(posedge clock_i);
    chk({24'h0, flashes}, {24'h0, fl0 + 8'h01});
    // Unmapped address: error, zero data, and a write there changes nothing.
    apb(1'b0, 8'h0c, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h0c, 32'h1f);
    apb(1'b0, LINE_CFG_ADDR, 32'h0);
    chk(rd, 32'h9);
    // Reset in mid-run while the line is driven.
    apb(1'b1, LINE_CFG_ADDR, 32'h1d);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk({31'h0, oe_n}, 32'h1);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    apb(1'b0, LINE_CFG_ADDR, 32'h0);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
